// ---- smr_pkg.sv ----
// Package with register map, field layout, reset values and timing counts for the mode port.
package smr_pkg;

  // Command word layout.
  localparam int unsigned SMR_WORD_BITS = 16;
  localparam int unsigned SMR_IDX_MSB = 14;
  localparam int unsigned SMR_IDX_LSB = 8;
  localparam int unsigned SMR_DATA_MSB = 7;

  // Register indices.
  localparam logic [6:0] SMR_IDX_LEFT_ATT = 7'h10;
  localparam logic [6:0] SMR_IDX_RIGHT_ATT = 7'h11;
  localparam logic [6:0] SMR_IDX_MUTE_OVS = 7'h12;
  localparam logic [6:0] SMR_IDX_DAC_DEEMPH = 7'h13;
  localparam logic [6:0] SMR_IDX_FMT_FLT = 7'h14;
  localparam logic [6:0] SMR_IDX_RSVD_TEST = 7'h15;
  localparam logic [6:0] SMR_IDX_ZERO_PHASE = 7'h16;

  // Field positions.
  localparam int unsigned SMR_OVS_BIT = 6;
  localparam int unsigned SMR_MUTE_R_BIT = 1;
  localparam int unsigned SMR_MUTE_L_BIT = 0;
  localparam int unsigned SMR_DIS_R_BIT = 1;
  localparam int unsigned SMR_DIS_L_BIT = 0;
  localparam int unsigned SMR_DEEMPH_EN_BIT = 4;
  localparam int unsigned SMR_DEEMPH_RATE_LSB = 5;
  localparam int unsigned SMR_ROLLOFF_BIT = 5;
  localparam int unsigned SMR_FMT_LSB = 0;
  localparam int unsigned SMR_ZCOMB_BIT = 2;
  localparam int unsigned SMR_ZPOL_BIT = 1;
  localparam int unsigned SMR_PHASE_BIT = 0;

  // Reset values.
  localparam logic [7:0] SMR_RST_ATT = 8'hff;
  localparam logic [7:0] SMR_RST_MUTE_OVS = 8'h00;
  localparam logic [7:0] SMR_RST_DAC_DEEMPH = 8'h00;
  localparam logic [7:0] SMR_RST_FMT_FLT = 8'h05;
  localparam logic [7:0] SMR_RST_RSVD = 8'h00;
  localparam logic [7:0] SMR_RST_ZERO_PHASE = 8'h00;

  // Attenuation codes at or below this value mean mute.
  localparam logic [7:0] SMR_ATT_MUTE_MAX = 8'h80;

  // Format codes.
  typedef enum logic [2:0] {
    SMR_FMT_RJ24 = 3'h0,
    SMR_FMT_RJ20 = 3'h1,
    SMR_FMT_RJ18 = 3'h2,
    SMR_FMT_RJ16 = 3'h3,
    SMR_FMT_I2S = 3'h4,
    SMR_FMT_LJ = 3'h5,
    SMR_FMT_RSV6 = 3'h6,
    SMR_FMT_RSV7 = 3'h7
  } smr_fmt_type;

  // Power-on initialisation interval, in system clocks.
  localparam int unsigned SMR_POR_CLOCKS = 1024;
  localparam logic [10:0] SMR_POR_LAST = 11'(SMR_POR_CLOCKS - 1);

endpackage

// ---- smr_sync.sv ----
// Two-stage synchroniser for a single level from another clock domain.
`timescale 1ns/10ps
module smr_sync
  import smr_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic async_i,
  output logic sync_o
);

  logic meta_r;
  logic sync_r;

  // The first stage feeds only the second stage, to contain metastability.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule

// ---- smr_shift.sv ----
// Serial command receiver: shifts command bits and reports complete words.
`timescale 1ns/10ps
module smr_shift
  import smr_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic shift_rise_i,
  input wire logic data_i,
  input wire logic latch_low_i,
  input wire logic latch_rise_i,
  output logic [15:0] word_o,
  output logic word_valid_o
);

  logic [15:0] shift_r;
  logic [4:0] count_r;
  logic [15:0] word_r;
  logic valid_r;

  // Bits enter at the bottom so the first bit sent ends as bit 15.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      shift_r <= 16'h0000;
      count_r <= 5'h00;
    end else if (latch_rise_i || !latch_low_i) begin
      count_r <= 5'h00;
    end else if (shift_rise_i) begin
      shift_r <= {shift_r[14:0], data_i};
      // Saturate so a seventeenth clock still marks the frame as overlong.
      if (count_r != 5'h11) begin
        count_r <= count_r + 5'h01;
      end
    end
  end

  // A word is only offered when exactly sixteen clocks came before the latch edge.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      word_r <= 16'h0000;
      valid_r <= 1'b0;
    end else begin
      valid_r <= latch_rise_i && (count_r == 5'(SMR_WORD_BITS));
      if (latch_rise_i) begin
        word_r <= shift_r;
      end
    end
  end

  assign word_o = word_r;
  assign word_valid_o = valid_r;

endmodule

// ---- smr_top.sv ----
// Mode register bank behind a three-wire serial control port.
//
// Overview of operation
// RULE_01: format_select picks right, I2S or left-justified.
// RULE_02: Format resets to 24-bit left-justified.
// RULE_03: Audio samples are MSB first, two's complement.
// RULE_04: Control port runs unrelated to audio timing.
// RULE_05: Shift clock shifts data; latch transfers word.
// RULE_06: Each write is exactly one 16-bit word.
// RULE_07: Host sends zero as the first bit.
// RULE_08: Bits 14 to 8 select the register.
// RULE_09: Low byte is the register data.
// RULE_10: Latch idles high, falls to start write.
// RULE_11: Host gives sixteen shift clocks while latch low.
// RULE_12: Latch rising edge commits the data byte.
// RULE_13: Registers decode at indices 10h through 16h.
// RULE_14: Two attenuation registers, default no attenuation.
// RULE_15: Oversampling bit six, mute bits one, zero.
// RULE_16: Disable bits one, zero; de-emphasis bit four.
// RULE_17: De-emphasis rate bits six, five; default 44.1k.
// RULE_18: Rolloff at bit five, format bits two-zero.
// RULE_19: Zero-flag combine, polarity, phase bits two-zero.
// RULE_20: Host writes zero to all reserved bits.
// RULE_21: Defaults load after 1024-clock power-on interval.
// RULE_22: Format codes: four RJ, I2S, LJ, two reserved.
// RULE_23: Attenuation codes 128 and below mean mute.
// RULE_24: Out-of-range index words change nothing.
// RULE_25: Latch after wrong clock count commits nothing.
`timescale 1ns/10ps
module smr_top
  import smr_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic control_serial_in_i,
  input wire logic control_shift_clock_i,
  input wire logic control_latch_i,
  output logic init_done_o,
  output logic [7:0] left_attenuation_level_o,
  output logic [7:0] right_attenuation_level_o,
  output logic left_att_mute_o,
  output logic right_att_mute_o,
  output logic rate_multiplier_select_o,
  output logic soft_silence_left_o,
  output logic soft_silence_right_o,
  output logic channel_disable_left_o,
  output logic channel_disable_right_o,
  output logic deemph_enable_o,
  output logic [1:0] deemph_rate_select_o,
  output logic rolloff_select_o,
  output logic [2:0] format_select_o,
  output logic format_reserved_o,
  output logic [4:0] format_width_o,
  output logic format_i2s_o,
  output logic format_left_justified_o,
  output logic zero_flag_combine_o,
  output logic zero_flag_polarity_o,
  output logic output_phase_invert_o,
  output logic [7:0] reserved_test_o,
  output logic command_ignored_o
);

  // ************************************************************
  // Power-on initialisation
  // ************************************************************

  typedef enum logic [1:0] {
    SMR_ST_INIT,
    SMR_ST_LOAD,
    SMR_ST_RUN
  } smr_state_type;

  smr_state_type state_r;
  smr_state_type state_nxt;
  logic [10:0] por_cnt_r;

  // Count the power-on interval before defaults are loaded.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      por_cnt_r <= 11'h000;
    end else if (state_r == SMR_ST_INIT) begin
      por_cnt_r <= por_cnt_r + 11'h001; // [RULE_21]
    end
  end

  // Defaults load one cycle after the interval, well inside one sample period.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SMR_ST_INIT: begin
        if (por_cnt_r == SMR_POR_LAST) begin
          state_nxt = SMR_ST_LOAD; // [RULE_21]
        end
      end
      SMR_ST_LOAD: begin
        state_nxt = SMR_ST_RUN;
      end
      SMR_ST_RUN: begin
        state_nxt = SMR_ST_RUN;
      end
      default: begin
        state_nxt = SMR_ST_INIT;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state_r <= SMR_ST_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign init_done_o = (state_r == SMR_ST_RUN);

  // ************************************************************
  // Control pin sampling
  // ************************************************************

  logic sdata_s;
  logic sclk_s;
  logic latch_s;
  logic sclk_d_r;
  logic latch_d_r;
  logic shift_rise;
  logic latch_rise;

  // Port pins are unrelated to the system clock, so each is synchronised first. [RULE_04]
  smr_sync u_sync_data (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(control_serial_in_i),
    .sync_o(sdata_s)
  );

  smr_sync u_sync_clk (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(control_shift_clock_i),
    .sync_o(sclk_s)
  );

  // The latch line idles high, so its synchroniser output is inverted to reset high.
  logic latch_n_s;
  smr_sync u_sync_latch (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(!control_latch_i),
    .sync_o(latch_n_s)
  );
  assign latch_s = !latch_n_s;

  // Edge detection on the synchronised levels.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sclk_d_r <= 1'b0;
      latch_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      latch_d_r <= latch_s;
    end
  end

  // Data is sampled on the shift clock's rising edge; the data path delay matches the clock's.
  assign shift_rise = sclk_s && !sclk_d_r; // [RULE_05]
  assign latch_rise = latch_s && !latch_d_r; // [RULE_12]

  // ************************************************************
  // Command word assembly
  // ************************************************************

  logic [15:0] word;
  logic word_valid;

  // Only sixteen-clock frames produce a word. [RULE_06] [RULE_25]
  smr_shift u_shift (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .shift_rise_i(shift_rise),
    .data_i(sdata_s),
    .latch_low_i(!latch_s),
    .latch_rise_i(latch_rise),
    .word_o(word),
    .word_valid_o(word_valid)
  );

  logic [6:0] cmd_index;
  logic [7:0] cmd_data;
  logic index_hit;

  // The leading bit is not checked; the host is trusted to send zero.
  assign cmd_index = word[SMR_IDX_MSB:SMR_IDX_LSB]; // [RULE_08]
  assign cmd_data = word[SMR_DATA_MSB:0]; // [RULE_09]

  // True when the index falls in the mapped window.
  function automatic logic smr_in_map(input logic [6:0] idx);
    smr_in_map = (idx >= SMR_IDX_LEFT_ATT) && (idx <= SMR_IDX_ZERO_PHASE);
  endfunction

  assign index_hit = smr_in_map(cmd_index); // [RULE_13]

  // Writes before defaults are loaded are dropped so the load cannot be overwritten early.
  logic wr_ok;
  assign wr_ok = word_valid && (state_r == SMR_ST_RUN);

  // ************************************************************
  // Mode registers
  // ************************************************************

  logic [7:0] left_att_r;
  logic [7:0] right_att_r;
  logic [7:0] mute_ovs_r;
  logic [7:0] dac_deemph_r;
  logic [7:0] fmt_flt_r;
  logic [7:0] rsvd_r;
  logic [7:0] zero_phase_r;
  logic load_defaults;

  assign load_defaults = (state_r != SMR_ST_RUN);

  // Each register takes its default until initialisation ends, then committed writes.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || load_defaults) begin
      left_att_r <= SMR_RST_ATT; // [RULE_14] [RULE_21]
      right_att_r <= SMR_RST_ATT; // [RULE_14]
      mute_ovs_r <= SMR_RST_MUTE_OVS; // [RULE_15]
      dac_deemph_r <= SMR_RST_DAC_DEEMPH; // [RULE_16] [RULE_17]
      fmt_flt_r <= SMR_RST_FMT_FLT; // [RULE_02] [RULE_18]
      rsvd_r <= SMR_RST_RSVD;
      zero_phase_r <= SMR_RST_ZERO_PHASE; // [RULE_19]
    end else if (wr_ok && index_hit) begin
      // Commit happens on the latch rising edge only. [RULE_12] [RULE_24]
      case (cmd_index)
        SMR_IDX_LEFT_ATT: begin
          left_att_r <= cmd_data; // [RULE_14]
        end
        SMR_IDX_RIGHT_ATT: begin
          right_att_r <= cmd_data; // [RULE_14]
        end
        SMR_IDX_MUTE_OVS: begin
          mute_ovs_r <= cmd_data; // [RULE_15]
        end
        SMR_IDX_DAC_DEEMPH: begin
          dac_deemph_r <= cmd_data; // [RULE_16] [RULE_17]
        end
        SMR_IDX_FMT_FLT: begin
          fmt_flt_r <= cmd_data; // [RULE_18]
        end
        SMR_IDX_RSVD_TEST: begin
          rsvd_r <= cmd_data;
        end
        SMR_IDX_ZERO_PHASE: begin
          zero_phase_r <= cmd_data; // [RULE_19]
        end
        default: begin
          rsvd_r <= rsvd_r;
        end
      endcase
    end
  end

  // Pulse when a well-formed frame is dropped for a bad index or during initialisation.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      command_ignored_o <= 1'b0;
    end else begin
      command_ignored_o <= word_valid && (!index_hit || load_defaults); // [RULE_24]
    end
  end

  // ************************************************************
  // Field decode
  // ************************************************************

  // Attenuation codes up to 128 are treated as full mute by the datapath.
  function automatic logic smr_att_is_mute(input logic [7:0] code);
    smr_att_is_mute = (code <= SMR_ATT_MUTE_MAX);
  endfunction

  smr_fmt_type fmt;
  assign fmt = smr_fmt_type'(fmt_flt_r[SMR_FMT_LSB +: 3]);

  // Sample width for right-justified modes; justified modes carry up to 24 bits MSB first.
  always_comb begin
    format_width_o = 5'd24;
    case (fmt)
      SMR_FMT_RJ24: format_width_o = 5'd24; // [RULE_22]
      SMR_FMT_RJ20: format_width_o = 5'd20;
      SMR_FMT_RJ18: format_width_o = 5'd18;
      SMR_FMT_RJ16: format_width_o = 5'd16;
      default: format_width_o = 5'd24; // [RULE_03]
    endcase
  end

  assign format_i2s_o = (fmt == SMR_FMT_I2S); // [RULE_01]
  assign format_left_justified_o = (fmt == SMR_FMT_LJ); // [RULE_01]
  assign format_reserved_o = fmt_flt_r[2] && fmt_flt_r[1]; // [RULE_22]
  assign format_select_o = fmt_flt_r[SMR_FMT_LSB +: 3];
  assign rolloff_select_o = fmt_flt_r[SMR_ROLLOFF_BIT];

  assign left_attenuation_level_o = left_att_r;
  assign right_attenuation_level_o = right_att_r;
  assign left_att_mute_o = smr_att_is_mute(left_att_r); // [RULE_23]
  assign right_att_mute_o = smr_att_is_mute(right_att_r); // [RULE_23]

  assign rate_multiplier_select_o = mute_ovs_r[SMR_OVS_BIT];
  assign soft_silence_left_o = mute_ovs_r[SMR_MUTE_L_BIT];
  assign soft_silence_right_o = mute_ovs_r[SMR_MUTE_R_BIT];

  assign channel_disable_left_o = dac_deemph_r[SMR_DIS_L_BIT];
  assign channel_disable_right_o = dac_deemph_r[SMR_DIS_R_BIT];
  assign deemph_enable_o = dac_deemph_r[SMR_DEEMPH_EN_BIT];
  assign deemph_rate_select_o = dac_deemph_r[SMR_DEEMPH_RATE_LSB +: 2];

  assign zero_flag_combine_o = zero_phase_r[SMR_ZCOMB_BIT];
  assign zero_flag_polarity_o = zero_phase_r[SMR_ZPOL_BIT];
  assign output_phase_invert_o = zero_phase_r[SMR_PHASE_BIT];

  // Test bits are exposed only so misuse is observable; the host should keep them zero.
  assign reserved_test_o = rsvd_r;

endmodule

// ---- smr_top_assertions.sv ----
// Assertion checker for the mode port register bank.
`timescale 1ns/10ps
module smr_top_assertions
  import smr_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic control_latch_i,
  input wire logic init_done_o,
  input wire logic [7:0] left_attenuation_level_o,
  input wire logic [7:0] right_attenuation_level_o,
  input wire logic left_att_mute_o,
  input wire logic right_att_mute_o,
  input wire logic rate_multiplier_select_o,
  input wire logic [2:0] format_select_o,
  input wire logic format_reserved_o,
  input wire logic [4:0] format_width_o,
  input wire logic format_i2s_o,
  input wire logic format_left_justified_o,
  input wire logic [7:0] reserved_test_o,
  input wire logic command_ignored_o
);
  // ********
  // Helpers
  // ********
  logic lat_r;
  logic [7:0] rise_age_r;
  logic [10:0] up_age_r;
  logic [27:0] regs;

  // Watched slice of the bank; the other fields share the same write path.
  assign regs = {left_attenuation_level_o, right_attenuation_level_o,
    rate_multiplier_select_o, format_select_o, reserved_test_o};

  // Cycles since the raw latch pin rose; saturates so long idles never wrap.
  always_ff @(posedge clk_i) begin
    lat_r <= control_latch_i;
    if (sys_rst_i) begin
      rise_age_r <= 8'hff;
    end else if (control_latch_i && !lat_r) begin
      rise_age_r <= 8'h00;
    end else if (rise_age_r != 8'hff) begin
      rise_age_r <= rise_age_r + 8'h01;
    end
  end

  // Cycles since reset was released.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      up_age_r <= 11'h000;
    end else if (up_age_r != 11'h7ff) begin
      up_age_r <= up_age_r + 11'h001;
    end
  end

  // ********
  // Properties
  // ********
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  a_reset_defaults: assert property (disable iff (1'b0) sys_rst_i |=> !init_done_o &&
    regs == {16'hffff, 1'b0, 3'h5, 8'h00}) else $error("Bank not at defaults after reset.");
  a_init_late: assert property (init_done_o |-> up_age_r >= 11'h400)
    else $error("Init done before the power-on count.");
  a_init_soon: assert property (up_age_r >= 11'h410 |-> init_done_o)
    else $error("Init done missing after the power-on count.");
  a_mute_left: assert property (left_att_mute_o == (left_attenuation_level_o <= 8'h80))
    else $error("Left mute decode wrong.");
  a_mute_right: assert property (right_att_mute_o == (right_attenuation_level_o <= 8'h80))
    else $error("Right mute decode wrong.");
  a_fmt_decode: assert property (format_i2s_o == (format_select_o == 3'h4) &&
    format_left_justified_o == (format_select_o == 3'h5) &&
    format_reserved_o == (format_select_o[2:1] == 2'h3)) else $error("Format decode wrong.");
  a_fmt_width: assert property (format_width_o == ((format_select_o == 3'h1) ? 5'h14 :
    (format_select_o == 3'h2) ? 5'h12 : (format_select_o == 3'h3) ? 5'h10 : 5'h18))
    else $error("Format width wrong.");
  a_write_hold: assert property (!control_latch_i [*8] |-> $stable(regs))
    else $error("Bank changed while latch low.");
  a_write_moment: assert property ($changed(regs) && !$past(sys_rst_i) |->
    rise_age_r inside {[1:8]}) else $error("Bank changed away from a latch rise.");
  a_ignore_pulse: assert property (command_ignored_o |=> !command_ignored_o)
    else $error("Ignore pulse longer than one cycle.");
  a_ignore_moment: assert property (command_ignored_o |-> rise_age_r inside {[1:8]})
    else $error("Ignore pulse away from a latch rise.");
  a_ignore_keep: assert property (command_ignored_o |-> $stable(regs) [*4])
    else $error("Ignored word changed the bank.");

  c_ignored: cover property (command_ignored_o);
  c_init: cover property ($rose(init_done_o));
  c_i2s: cover property (format_i2s_o);
  c_mute: cover property (left_att_mute_o && !right_att_mute_o);
endmodule

bind smr_top smr_top_assertions i_chk (.clk_i, .sys_rst_i, .control_latch_i, .init_done_o,
  .left_attenuation_level_o, .right_attenuation_level_o, .left_att_mute_o, .right_att_mute_o,
  .rate_multiplier_select_o, .format_select_o, .format_reserved_o, .format_width_o,
  .format_i2s_o, .format_left_justified_o, .reserved_test_o, .command_ignored_o);

// ---- smr_host.sv ----
// Host model that writes command words into the three-wire control port.
`timescale 1ns/10ps
module smr_host (
  input wire logic clk_i,
  output logic control_serial_in_o,
  output logic control_shift_clock_o,
  output logic control_latch_o
);
  // ********
  // Host side
  // ********

  // Idle state: latch high, shift clock parked low between frames.
  initial begin
    control_latch_o = 1'b1;
    control_shift_clock_o = 1'b0;
    control_serial_in_o = 1'b0;
  end

  // Sends nbits of w, MSB first; any count but 16 makes a broken frame on purpose.
  task automatic send(input logic [15:0] w, input int nbits);
    @(posedge clk_i);
    #1 control_latch_o = 1'b0;
    #160;
    for (int i = 0; i < nbits; i++) begin
      control_serial_in_o = (i < 16) ? w[15 - i] : ~control_serial_in_o;
      #160 control_shift_clock_o = 1'b1;
      #160 control_shift_clock_o = 1'b0;
    end
    #160 control_latch_o = 1'b1;
    // Data line is flipped so a stale bit is never read as valid.
    control_serial_in_o = ~control_serial_in_o;
    #320;
  endtask
endmodule

// ---- smr_top_bench.sv ----
// Self-checking bench for the mode port register bank.
`timescale 1ns/10ps
module smr_top_bench;
  // ********
  // Signals
  // ********
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic control_serial_in_i, control_shift_clock_i, control_latch_i;
  logic [7:0] left_attenuation_level_o, right_attenuation_level_o, reserved_test_o;
  logic [4:0] format_width_o;
  logic [2:0] format_select_o;
  logic [1:0] deemph_rate_select_o;
  logic init_done_o, left_att_mute_o, right_att_mute_o, rate_multiplier_select_o;
  logic soft_silence_left_o, soft_silence_right_o, channel_disable_left_o;
  logic channel_disable_right_o, deemph_enable_o, rolloff_select_o, format_reserved_o;
  logic format_i2s_o, format_left_justified_o, zero_flag_combine_o, zero_flag_polarity_o;
  logic output_phase_invert_o, command_ignored_o;
  int miscompares = 0;
  int n_compared = 0;
  logic [7:0] mdl [16:22];
  logic [7:0] msk [16:22] = '{8'hff, 8'hff, 8'h43, 8'h73, 8'h27, 8'h00, 8'h07};
  logic [7:0] bnd [4] = '{8'h00, 8'h80, 8'h81, 8'hff};
  logic [6:0] bad [4] = '{7'h00, 7'h0f, 7'h17, 7'h7f};
  logic [56:0] exp_q [$];

  // Free-running 25 MHz clock.
  always #20 clk_i = ~clk_i;

  smr_top i_smr_top (.clk_i, .sys_rst_i, .control_serial_in_i, .control_shift_clock_i,
    .control_latch_i, .init_done_o, .left_attenuation_level_o, .right_attenuation_level_o,
    .left_att_mute_o, .right_att_mute_o, .rate_multiplier_select_o, .soft_silence_left_o,
    .soft_silence_right_o, .channel_disable_left_o, .channel_disable_right_o,
    .deemph_enable_o, .deemph_rate_select_o, .rolloff_select_o, .format_select_o,
    .format_reserved_o, .format_width_o, .format_i2s_o, .format_left_justified_o,
    .zero_flag_combine_o, .zero_flag_polarity_o, .output_phase_invert_o, .reserved_test_o,
    .command_ignored_o);

  smr_host i_smr_host (.clk_i, .control_serial_in_o(control_serial_in_i),
    .control_shift_clock_o(control_shift_clock_i), .control_latch_o(control_latch_i));

  // ********
  // Tasks
  // ********
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask

  task automatic end_sim;
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Notes the expected bank and ignore pulse, then sends the word.
  task automatic cmd(input logic [6:0] idx, input logic [7:0] d, input int n, input bit pre);
    bit ok;
    ok = (n == 16) && !pre && idx >= 7'h10 && idx <= 7'h16;
    if (ok) mdl[idx] = d;
    exp_q.push_back({n == 16 && !ok, mdl[16], mdl[17], mdl[18], mdl[19], mdl[20], mdl[21],
      mdl[22]});
    i_smr_host.send({1'b0, idx, d}, n);
  endtask

  // Reset, a dropped early frame that also checks defaults, then wait for init.
  task automatic rst_run;
    sys_rst_i = 1'b1;
    for (int i = 16; i <= 22; i++) mdl[i] = 8'h00;
    mdl[16] = 8'hff;
    mdl[17] = 8'hff;
    mdl[20] = 8'h05;
    repeat (16) @(posedge clk_i);
    #1 sys_rst_i = 1'b0;
    repeat (100) @(posedge clk_i);
    cmd(7'h10, 8'h00, 16, 1'b1);
    // Polled on the falling edge so the flag is read while it stands, not as it is launched.
    for (int k = 0; k < 1200 && init_done_o !== 1'b1; k++) @(negedge clk_i);
    chk("init_done", 8'h01, {7'h0, init_done_o});
  endtask

  // Monitor: a latch rise ends a frame; the answer lands within eight cycles.
  initial begin
    logic [56:0] e;
    logic [3:0] ic;
    logic [2:0] f;
    logic [4:0] w;
    forever begin
      @(posedge control_latch_i);
      ic = 4'h0;
      repeat (8) begin
        @(negedge clk_i);
        if (command_ignored_o === 1'b1) ic++;
      end
      if (exp_q.size() != 0) begin
        e = exp_q.pop_front();
        f = e[18:16];
        w = (f == 3'h1) ? 5'h14 : (f == 3'h2) ? 5'h12 : (f == 3'h3) ? 5'h10 : 5'h18;
        chk("ignored", {7'h0, e[56]}, {4'h0, ic});
        chk("left_att", e[55:48], left_attenuation_level_o);
        chk("right_att", e[47:40], right_attenuation_level_o);
        chk("reg12", e[39:32] & 8'h43, {1'b0, rate_multiplier_select_o, 4'h0,
          soft_silence_right_o, soft_silence_left_o});
        chk("reg13", e[31:24] & 8'h73, {1'b0, deemph_rate_select_o, deemph_enable_o,
          2'h0, channel_disable_right_o, channel_disable_left_o});
        chk("reg14", e[23:16] & 8'h27, {2'h0, rolloff_select_o, 2'h0, format_select_o});
        chk("reg15", e[15:8], reserved_test_o);
        chk("reg16", e[7:0] & 8'h07, {5'h0, zero_flag_combine_o, zero_flag_polarity_o,
          output_phase_invert_o});
        chk("att_mute", {6'h0, e[55:48] <= 8'h80, e[47:40] <= 8'h80},
          {6'h0, left_att_mute_o, right_att_mute_o});
        chk("fmt_dec", {f[2:1] == 2'h3, f == 3'h4, f == 3'h5, w}, {format_reserved_o,
          format_i2s_o, format_left_justified_o, format_width_o});
      end
    end
  end

  // Main sequence.
  initial begin
    void'($urandom(72207));
    rst_run();
    for (int i = 16; i <= 22; i++) cmd(7'(i), 8'($urandom()) & msk[i], 16, 1'b0);
    for (int i = 0; i < 8; i++) cmd(7'h14, 8'(i), 16, 1'b0);
    foreach (bnd[i]) begin
      cmd(7'h10, bnd[i], 16, 1'b0);
      cmd(7'h11, ~bnd[i], 16, 1'b0);
    end
    foreach (bad[i]) cmd(bad[i], 8'h5a, 16, 1'b0);
    cmd(7'h10, 8'h33, 15, 1'b0);
    cmd(7'h11, 8'h33, 17, 1'b0);
    @(posedge clk_i);
    #1 rst_run();
    end_sim();
  end

  // Watchdog, sized well past the expected run of about 6300 cycles.
  initial begin
    #1000000;
    miscompares++;
    end_sim();
  end
endmodule
